// ### rtl/pbi_bus_if.sv
// pbi_bus_if: shared bus wires, resolved from each end's drive and enable
// assumes at most one end enables a given wire; undriven wires pull high
`timescale 1ns/1ps
interface pbi_bus_if;
  logic [31:0] dev_ad_o,  hst_ad_o,  ad;
  logic        dev_ad_oe, hst_ad_oe;
  logic [3:0]  dev_cbe_o, hst_cbe_o, cbe_n, dev_cbe_oe, hst_cbe_oe;
  logic [3:0]  dev_ctl_o, hst_ctl_o, ctl_n, dev_ctl_oe, hst_ctl_oe;
  logic        req_n;
  logic        gnt_n;
  logic        idsel;
  logic        dev_int_oe;
  logic        int_n;

  assign ad    = ({32{dev_ad_oe}} & dev_ad_o) | ({32{hst_ad_oe}} & hst_ad_o) |
                 ~{32{dev_ad_oe | hst_ad_oe}};
  assign cbe_n = (dev_cbe_oe & dev_cbe_o) | (hst_cbe_oe & hst_cbe_o) |
                 ~(dev_cbe_oe | hst_cbe_oe);
  assign ctl_n = (dev_ctl_oe & dev_ctl_o) | (hst_ctl_oe & hst_ctl_o) |
                 ~(dev_ctl_oe | hst_ctl_oe);
  // open drain: low only while the device enables its driver
  assign int_n = ~dev_int_oe;

  modport dev (output dev_ad_o, dev_ad_oe, dev_cbe_o, dev_cbe_oe, dev_ctl_o, dev_ctl_oe,
               output req_n, dev_int_oe,
               input  ad, cbe_n, ctl_n, gnt_n, idsel);
  modport hst (output hst_ad_o, hst_ad_oe, hst_cbe_o, hst_cbe_oe, hst_ctl_o, hst_ctl_oe,
               output gnt_n, idsel,
               input  ad, cbe_n, ctl_n, req_n, int_n);
endinterface

// ### rtl/pbi_dev_end.sv
// pbi_dev_end: device end; io/config target, memory master, interrupt line
// assumes the bus clock is core_clk and the host end arbitrates the bus
`timescale 1ns/1ps
// Notes on behaviour
// (R1) address phase carries the bus command
// (R2) data phases carry active-low byte enables
// (R3) master and io accesses enable all bytes
// (R4) config accesses honour any byte-enable pattern
// (R5) all bus inputs sampled on rising clock
// (R6) system supplies bus clock 16 to 33 MHz; the bench runs core_clk at 200 MHz
// (R7) device select asserted on own decode
// (R8) medium decode: select by second clock
// (R9) target must select within five clocks
// (R10) no select in window: master abort
// (R11) frame asserted at start, held while data
// (R12) frame released before the last data phase
// (R13) master transactions start only when granted
// (R14) config cycles answered only with init select
// (R15) interrupt when unmasked status bit set
// (R16) write one clears status, line then released
// (R17) partial clear drops line for one clock
// (R18) initiator ready when data valid or acceptable
module pbi_dev_end #(
  parameter int          NUM_EVT = 8,
  parameter logic [31:0] ID_WORD = 32'h0a5a_0001  // arbitrary identity value
) (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  pbi_bus_if.dev                  bus,
  input  wire logic [NUM_EVT-1:0] evt_set,
  input  wire logic               mst_req,
  input  wire logic               mst_write,
  input  wire logic [31:0]        mst_addr,
  input  wire logic [3:0]         mst_len,
  input  wire logic [31:0]        mst_wdata,
  output logic      [3:0]         mst_widx,
  output logic      [31:0]        mst_rdata,
  output logic                    mst_rvalid,
  output logic                    mst_done,
  output logic                    mst_abort
);
  if (NUM_EVT < 1 || NUM_EVT > 32) begin : g_chk
    $error("pbi_dev_end: NUM_EVT must be 1..32");
  end

  typedef enum logic [1:0] {T_IDLE = 2'b00, T_DEC = 2'b01, T_TURN = 2'b11,
                            T_DATA = 2'b10} pbi_tst_t;
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_ADDR = 2'b01, M_DATA = 2'b11,
                            M_END = 2'b10} pbi_mst_t;

  logic        frame_n, irdy_n, trdy_n, devsel_n;
  assign frame_n  = bus.ctl_n[pbi_pkg::CTL_FRAME];
  assign irdy_n   = bus.ctl_n[pbi_pkg::CTL_IRDY];
  assign trdy_n   = bus.ctl_n[pbi_pkg::CTL_TRDY];
  assign devsel_n = bus.ctl_n[pbi_pkg::CTL_DEVSEL];

  pbi_tst_t     t_st_ff;
  pbi_mst_t     m_st_ff;
  logic         frame_q_ff;
  logic [31:0]  t_addr_ff, t_ad_ff, m_ad_ff, rdata_ff;
  logic [3:0]   t_cmd_ff, m_cbe_ff, left_ff, widx_ff;
  logic         t_idsel_ff, t_sel_ff, t_trdy_ff, t_oe_ff, t_ad_oe_ff;
  logic         m_frame_ff, m_irdy_ff, m_oe_ff, m_ad_oe_ff, req_n_ff;
  logic         rvalid_ff, done_ff, abort_ff, int_oe_ff;
  logic [2:0]   wait_ff;
  logic [31:0]  cfg_ff [0:7];
  logic [NUM_EVT-1:0] stat_ff, mask_ff, clr, nxt_stat;

  function automatic logic is_wr(input logic [3:0] c);
    return c[0];
  endfunction

  function automatic logic [31:0] be_mask(input logic [3:0] be_n);
    return {{8{~be_n[3]}}, {8{~be_n[2]}}, {8{~be_n[1]}}, {8{~be_n[0]}}};
  endfunction

  // own decode of the captured address phase
  logic cfg_hit, io_hit, tgt_wr, io_en, mst_en;
  assign io_en   = cfg_ff[pbi_pkg::CFG_CMD_IDX][pbi_pkg::CMD_IOEN];
  assign mst_en  = cfg_ff[pbi_pkg::CFG_CMD_IDX][pbi_pkg::CMD_MSTEN];
  assign cfg_hit = t_idsel_ff && t_addr_ff[1:0] == 2'h0 &&                        // R14
                   (t_cmd_ff == pbi_pkg::CMD_CFG_RD || t_cmd_ff == pbi_pkg::CMD_CFG_WR);
  assign io_hit  = io_en && t_addr_ff[31:5] == cfg_ff[pbi_pkg::CFG_BAR_IDX][31:5] &&
                   (t_cmd_ff == pbi_pkg::CMD_IO_RD || t_cmd_ff == pbi_pkg::CMD_IO_WR);
  assign tgt_wr  = t_st_ff == T_DATA && !irdy_n && is_wr(t_cmd_ff);

  function automatic logic [31:0] rd_word(input logic [31:0] a, input logic cfg);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (cfg) begin
      w = (a[4:2] == pbi_pkg::CFG_ID_IDX) ? ID_WORD : cfg_ff[a[4:2]];
    end else if (a[4:0] == pbi_pkg::IO_STAT_OFS) begin
      w[NUM_EVT-1:0] = stat_ff;
    end else if (a[4:0] == pbi_pkg::IO_MASK_OFS) begin
      w[NUM_EVT-1:0] = mask_ff;
    end
    return w;
  endfunction

  // target: address taken at edge k, select driven after k+1, seen at k+2
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      t_st_ff    <= T_IDLE;
      frame_q_ff <= 1'b1;
      t_addr_ff  <= 32'h0000_0000;
      t_cmd_ff   <= 4'h0;
      t_idsel_ff <= 1'b0;
      t_sel_ff   <= 1'b1;
      t_trdy_ff  <= 1'b1;
      t_oe_ff    <= 1'b0;
      t_ad_ff    <= 32'h0000_0000;
      t_ad_oe_ff <= 1'b0;
    end else begin
      frame_q_ff <= frame_n;                                                       // R5
      unique case (t_st_ff)
        T_IDLE: begin
          if (!frame_n && frame_q_ff && m_st_ff == M_IDLE) begin
            t_addr_ff  <= bus.ad;
            t_cmd_ff   <= bus.cbe_n;                                               // R1
            t_idsel_ff <= bus.idsel;
            t_st_ff    <= T_DEC;
          end
        end
        T_DEC: begin
          if (cfg_hit || io_hit) begin
            t_sel_ff <= 1'b0;                                                      // R7 R8
            t_oe_ff  <= 1'b1;
            t_st_ff  <= T_TURN;
          end else begin
            t_st_ff <= T_IDLE;
          end
        end
        T_TURN: begin
          t_trdy_ff <= 1'b0;
          if (!is_wr(t_cmd_ff)) begin
            t_ad_ff    <= rd_word(t_addr_ff, cfg_hit);
            t_ad_oe_ff <= 1'b1;
          end
          t_st_ff <= T_DATA;
        end
        T_DATA: begin
          // single data phase only; a longer burst is not served
          if (!irdy_n) begin
            t_sel_ff   <= 1'b1;
            t_trdy_ff  <= 1'b1;
            t_oe_ff    <= 1'b0;
            t_ad_oe_ff <= 1'b0;
            t_st_ff    <= T_IDLE;
          end
        end
      endcase
    end
  end

  // config space, byte lanes written as enabled
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        cfg_ff[i] <= pbi_pkg::CFG_RST;
      end
    end else if (tgt_wr && cfg_hit && t_addr_ff[4:2] != pbi_pkg::CFG_ID_IDX) begin
      for (int b = 0; b < 4; b++) begin
        if (!bus.cbe_n[b]) begin                                                   // R2 R4
          cfg_ff[t_addr_ff[4:2]][8*b +: 8] <= bus.ad[8*b +: 8];
        end
      end
    end
  end

  // lane mask of the current data phase, sliced to the event width below
  logic [31:0] be_bits;
  assign be_bits = be_mask(bus.cbe_n);

  // status clear by writing ones; a new event wins over the clear
  always_comb begin
    clr = '0;
    if (tgt_wr && io_hit && t_addr_ff[4:0] == pbi_pkg::IO_STAT_OFS) begin
      clr = bus.ad[NUM_EVT-1:0] & be_bits[NUM_EVT-1:0];                            // R16
    end
    nxt_stat = (stat_ff & ~clr) | evt_set;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stat_ff <= '0;
      mask_ff <= pbi_pkg::MASK_RST[NUM_EVT-1:0];
    end else begin
      stat_ff <= nxt_stat;
      if (tgt_wr && io_hit && t_addr_ff[4:0] == pbi_pkg::IO_MASK_OFS) begin
        mask_ff <= (mask_ff & ~be_bits[NUM_EVT-1:0]) |
                   (bus.ad[NUM_EVT-1:0] & be_bits[NUM_EVT-1:0]);
      end
    end
  end

  // mask bit set blocks; a clear that leaves others pending blinks the line
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      int_oe_ff <= 1'b0;
    end else begin
      int_oe_ff <= |(nxt_stat & ~mask_ff) &&                                        // R15 R16
                   !(int_oe_ff && |(clr & stat_ff));                                // R17
    end
  end

  // master: memory read or write of mst_len data phases, one phase when mst_len is 0
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      m_st_ff    <= M_IDLE;
      m_frame_ff <= 1'b1;
      m_irdy_ff  <= 1'b1;
      m_oe_ff    <= 1'b0;
      m_ad_ff    <= 32'h0000_0000;
      m_ad_oe_ff <= 1'b0;
      m_cbe_ff   <= 4'hf;
      left_ff    <= 4'h0;
      widx_ff    <= 4'h0;
      wait_ff    <= 3'h0;
      rdata_ff   <= 32'h0000_0000;
      rvalid_ff  <= 1'b0;
      done_ff    <= 1'b0;
      abort_ff   <= 1'b0;
      req_n_ff   <= 1'b1;
    end else begin
      rvalid_ff <= 1'b0;
      done_ff   <= 1'b0;
      abort_ff  <= 1'b0;
      unique case (m_st_ff)
        M_IDLE: begin
          req_n_ff <= !(mst_req && mst_en);
          if (mst_req && mst_en && !bus.gnt_n && frame_n && irdy_n &&               // R13
              t_st_ff == T_IDLE) begin
            m_frame_ff <= 1'b0;                                                    // R11
            m_oe_ff    <= 1'b1;
            m_ad_ff    <= mst_addr;
            m_ad_oe_ff <= 1'b1;
            m_cbe_ff   <= mst_write ? pbi_pkg::CMD_MEM_WR : pbi_pkg::CMD_MEM_RD;   // R1
            left_ff    <= (mst_len == 4'h0) ? 4'h1 : mst_len;
            widx_ff    <= 4'h0;
            req_n_ff   <= 1'b1;
            m_st_ff    <= M_ADDR;
          end
        end
        M_ADDR: begin
          m_cbe_ff   <= pbi_pkg::BE_ALL;                                           // R3
          m_irdy_ff  <= 1'b0;                                                      // R18
          m_frame_ff <= (left_ff == 4'h1);                                         // R12
          wait_ff    <= 3'h1;
          if (is_wr(m_cbe_ff)) begin
            m_ad_ff <= mst_wdata;
            widx_ff <= 4'h1;
          end else begin
            m_ad_oe_ff <= 1'b0;
          end
          m_st_ff <= M_DATA;
        end
        M_DATA: begin
          if (!devsel_n && !trdy_n) begin
            rdata_ff  <= bus.ad;
            rvalid_ff <= !is_wr(m_cbe_ff ^ pbi_pkg::BE_ALL) && !m_ad_oe_ff;
            left_ff   <= left_ff - 4'h1;
            if (left_ff == 4'h1) begin
              m_irdy_ff  <= 1'b1;
              m_ad_oe_ff <= 1'b0;
              done_ff    <= 1'b1;
              m_st_ff    <= M_END;
            end else begin
              m_frame_ff <= (left_ff == 4'h2);                                     // R11 R12
              if (m_ad_oe_ff) begin
                m_ad_ff <= mst_wdata;
                widx_ff <= widx_ff + 4'h1;
              end
            end
          end else if (devsel_n && wait_ff == pbi_pkg::DEVSEL_WAIT) begin          // R9 R10
            m_frame_ff <= 1'b1;
            m_irdy_ff  <= 1'b1;
            m_ad_oe_ff <= 1'b0;
            abort_ff   <= 1'b1;
            done_ff    <= 1'b1;
            m_st_ff    <= M_END;
          end else if (devsel_n) begin
            wait_ff <= wait_ff + 3'h1;
          end
        end
        M_END: begin
          // frame and irdy driven high for one cycle before release
          m_oe_ff <= 1'b0;
          m_st_ff <= M_IDLE;
        end
      endcase
    end
  end

  assign bus.dev_ad_o   = t_ad_oe_ff ? t_ad_ff : m_ad_ff;
  assign bus.dev_ad_oe  = t_ad_oe_ff | m_ad_oe_ff;
  assign bus.dev_cbe_o  = m_cbe_ff;
  assign bus.dev_cbe_oe = {4{m_oe_ff && m_st_ff != M_END}};
  assign bus.dev_ctl_o  = {m_frame_ff, m_irdy_ff, t_trdy_ff, t_sel_ff};
  assign bus.dev_ctl_oe = {m_oe_ff, m_oe_ff, t_oe_ff, t_oe_ff};
  assign bus.req_n      = req_n_ff;
  assign bus.dev_int_oe = int_oe_ff;
  assign mst_widx       = widx_ff;
  assign mst_rdata      = rdata_ff;
  assign mst_rvalid     = rvalid_ff;
  assign mst_done       = done_ff;
  assign mst_abort      = abort_ff;
endmodule

// ### rtl/pbi_hst_end.sv
// pbi_hst_end: host end; arbiter, single-phase master, memory target
// assumes core_clk is the bus clock, kept by the system within 16..33 MHz
`timescale 1ns/1ps
module pbi_hst_end #(
  parameter int MEM_WORDS = 16
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  pbi_bus_if.hst           bus,
  input  wire logic        h_req,
  input  wire logic [3:0]  h_cmd,
  input  wire logic [31:0] h_addr,
  input  wire logic [3:0]  h_be_n,
  input  wire logic [31:0] h_wdata,
  output logic      [31:0] h_rdata,
  output logic             h_done,
  output logic             h_abort,
  output logic             h_irq
);
  if (MEM_WORDS < 2 || MEM_WORDS > 256) begin : g_chk
    $error("pbi_hst_end: MEM_WORDS must be 2..256");
  end
  localparam int AW = $clog2(MEM_WORDS);

  typedef enum logic [1:0] {H_IDLE = 2'b00, H_ADDR = 2'b01, H_DATA = 2'b11,
                            H_END = 2'b10} pbi_hst_t;
  typedef enum logic [1:0] {G_IDLE = 2'b00, G_DEC = 2'b01, G_TURN = 2'b11,
                            G_DATA = 2'b10} pbi_gtg_t;

  logic frame_n, irdy_n, trdy_n, devsel_n;
  assign frame_n  = bus.ctl_n[pbi_pkg::CTL_FRAME];
  assign irdy_n   = bus.ctl_n[pbi_pkg::CTL_IRDY];
  assign trdy_n   = bus.ctl_n[pbi_pkg::CTL_TRDY];
  assign devsel_n = bus.ctl_n[pbi_pkg::CTL_DEVSEL];

  pbi_hst_t     h_st_ff;
  pbi_gtg_t     g_st_ff;
  logic         gnt_n_ff, idsel_ff, frame_q_ff, irq_ff;
  logic         m_frame_ff, m_irdy_ff, m_oe_ff, m_ad_oe_ff;
  logic [31:0]  m_ad_ff, rdata_ff, g_ad_ff;
  logic [3:0]   m_cbe_ff, g_cmd_ff;
  logic [2:0]   wait_ff;
  logic         done_ff, abort_ff, g_sel_ff, g_trdy_ff, g_oe_ff, g_ad_oe_ff;
  logic [AW-1:0] g_idx_ff;
  logic [31:0]  mem_ff [0:MEM_WORDS-1];

  // arbiter: device first; grant only while the host master rests
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gnt_n_ff <= 1'b1;
      irq_ff   <= 1'b0;
    end else begin
      gnt_n_ff <= !(h_st_ff == H_IDLE && !bus.req_n);                              // R13
      irq_ff   <= !bus.int_n;
    end
  end

  // master: one data phase of any command, byte enables as given for config, all bytes otherwise
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      h_st_ff    <= H_IDLE;
      m_frame_ff <= 1'b1;
      m_irdy_ff  <= 1'b1;
      m_oe_ff    <= 1'b0;
      m_ad_ff    <= 32'h0000_0000;
      m_ad_oe_ff <= 1'b0;
      m_cbe_ff   <= 4'hf;
      idsel_ff   <= 1'b0;
      wait_ff    <= 3'h0;
      rdata_ff   <= 32'h0000_0000;
      done_ff    <= 1'b0;
      abort_ff   <= 1'b0;
    end else begin
      done_ff  <= 1'b0;
      abort_ff <= 1'b0;
      unique case (h_st_ff)
        H_IDLE: begin
          if (h_req && gnt_n_ff && bus.req_n && frame_n && irdy_n &&
              g_st_ff == G_IDLE) begin
            m_frame_ff <= 1'b0;
            m_oe_ff    <= 1'b1;
            m_ad_ff    <= h_addr;
            m_ad_oe_ff <= 1'b1;
            m_cbe_ff   <= h_cmd;
            idsel_ff   <= (h_cmd == pbi_pkg::CMD_CFG_RD || h_cmd == pbi_pkg::CMD_CFG_WR);
            h_st_ff    <= H_ADDR;
          end
        end
        H_ADDR: begin
          idsel_ff   <= 1'b0;
          m_frame_ff <= 1'b1;
          m_irdy_ff  <= 1'b0;
          wait_ff    <= 3'h1;
          m_cbe_ff   <= (m_cbe_ff == pbi_pkg::CMD_CFG_RD || m_cbe_ff == pbi_pkg::CMD_CFG_WR)
                        ? h_be_n : pbi_pkg::BE_ALL;
          if (m_cbe_ff[0]) begin
            m_ad_ff <= h_wdata;
          end else begin
            m_ad_oe_ff <= 1'b0;
          end
          h_st_ff <= H_DATA;
        end
        H_DATA: begin
          if ((!devsel_n && !trdy_n) || (devsel_n && wait_ff == pbi_pkg::DEVSEL_WAIT)) begin
            rdata_ff   <= bus.ad;
            abort_ff   <= devsel_n;
            done_ff    <= 1'b1;
            m_irdy_ff  <= 1'b1;
            m_ad_oe_ff <= 1'b0;
            h_st_ff    <= H_END;
          end else if (devsel_n) begin
            wait_ff <= wait_ff + 3'h1;
          end
        end
        H_END: begin
          m_oe_ff <= 1'b0;
          h_st_ff <= H_IDLE;
        end
      endcase
    end
  end

  // memory target for the device's bursts, medium select timing
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      g_st_ff    <= G_IDLE;
      frame_q_ff <= 1'b1;
      g_cmd_ff   <= 4'h0;
      g_idx_ff   <= '0;
      g_sel_ff   <= 1'b1;
      g_trdy_ff  <= 1'b1;
      g_oe_ff    <= 1'b0;
      g_ad_ff    <= 32'h0000_0000;
      g_ad_oe_ff <= 1'b0;
    end else begin
      frame_q_ff <= frame_n;
      unique case (g_st_ff)
        G_IDLE: begin
          if (!frame_n && frame_q_ff && h_st_ff == H_IDLE) begin
            g_cmd_ff <= bus.cbe_n;
            g_idx_ff <= bus.ad[AW+1:2];
            g_st_ff  <= G_DEC;
          end
        end
        G_DEC: begin
          if (g_cmd_ff == pbi_pkg::CMD_MEM_RD || g_cmd_ff == pbi_pkg::CMD_MEM_WR) begin
            g_sel_ff <= 1'b0;                                                      // R9
            g_oe_ff  <= 1'b1;
            g_st_ff  <= G_TURN;
          end else begin
            g_st_ff <= G_IDLE;
          end
        end
        G_TURN: begin
          g_trdy_ff  <= 1'b0;
          g_ad_ff    <= mem_ff[g_idx_ff];
          g_ad_oe_ff <= !g_cmd_ff[0];
          g_st_ff    <= G_DATA;
        end
        G_DATA: begin
          if (!irdy_n) begin
            g_idx_ff <= g_idx_ff + 1'b1;
            g_ad_ff  <= mem_ff[g_idx_ff + 1'b1];
            if (frame_n) begin
              g_sel_ff   <= 1'b1;
              g_trdy_ff  <= 1'b1;
              g_oe_ff    <= 1'b0;
              g_ad_oe_ff <= 1'b0;
              g_st_ff    <= G_IDLE;
            end
          end else if (frame_n && irdy_n) begin
            g_sel_ff   <= 1'b1;
            g_trdy_ff  <= 1'b1;
            g_oe_ff    <= 1'b0;
            g_ad_oe_ff <= 1'b0;
            g_st_ff    <= G_IDLE;
          end
        end
      endcase
    end
  end

  // memory contents have no reset; the bench loads them by writes
  always_ff @(posedge core_clk) begin
    if (g_st_ff == G_DATA && !irdy_n && g_cmd_ff[0]) begin
      for (int b = 0; b < 4; b++) begin
        if (!bus.cbe_n[b]) begin
          mem_ff[g_idx_ff][8*b +: 8] <= bus.ad[8*b +: 8];
        end
      end
    end
  end

  assign bus.hst_ad_o   = g_ad_oe_ff ? g_ad_ff : m_ad_ff;
  assign bus.hst_ad_oe  = g_ad_oe_ff | m_ad_oe_ff;
  assign bus.hst_cbe_o  = m_cbe_ff;
  assign bus.hst_cbe_oe = {4{m_oe_ff && h_st_ff != H_END}};
  assign bus.hst_ctl_o  = {m_frame_ff, m_irdy_ff, g_trdy_ff, g_sel_ff};
  assign bus.hst_ctl_oe = {m_oe_ff, m_oe_ff, g_oe_ff, g_oe_ff};
  assign bus.gnt_n      = gnt_n_ff;
  assign bus.idsel      = idsel_ff;
  assign h_rdata        = rdata_ff;
  assign h_done         = done_ff;
  assign h_abort        = abort_ff;
  assign h_irq          = irq_ff;
endmodule

// ### rtl/pbi_pkg.sv
// pbi_pkg: shared constants of the expansion bus ends
// assumes both ends run on core_clk, which is the bus clock
package pbi_pkg;
  localparam logic [3:0] CMD_IO_RD   = 4'h2;
  localparam logic [3:0] CMD_IO_WR   = 4'h3;
  localparam logic [3:0] CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] CMD_MEM_WR  = 4'h7;
  localparam logic [3:0] CMD_CFG_RD  = 4'ha;
  localparam logic [3:0] CMD_CFG_WR  = 4'hb;
  localparam logic [3:0] BE_ALL      = 4'h0;
  localparam int         CTL_FRAME   = 3;
  localparam int         CTL_IRDY    = 2;
  localparam int         CTL_TRDY    = 1;
  localparam int         CTL_DEVSEL  = 0;
  localparam logic [2:0] DEVSEL_WAIT = 3'h5;
  localparam int         BUS_MHZ_MIN = 16;
  localparam int         BUS_MHZ_MAX = 33;
  localparam int         CORE_MHZ    = 200;
  localparam logic [2:0] CFG_ID_IDX  = 3'h0;
  localparam logic [2:0] CFG_CMD_IDX = 3'h1;
  localparam logic [2:0] CFG_BAR_IDX = 3'h4;
  localparam int         CMD_IOEN    = 0;
  localparam int         CMD_MSTEN   = 2;
  localparam logic [4:0] IO_STAT_OFS = 5'h00;
  localparam logic [4:0] IO_MASK_OFS = 5'h04;
  localparam logic [31:0] CFG_RST    = 32'h0000_0000;
  localparam logic [31:0] MASK_RST   = 32'hffff_ffff;
endpackage

// ### tb/pbi_bus_properties.sv
// pbi_bus_properties: timing checks on the shared bus wires
// assumes one clock domain and the synchronous high reset of both ends
`timescale 1ns/1ps
module pbi_bus_properties (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe_n,
  input wire logic [3:0]  ctl_n,
  input wire logic [3:0]  dev_ctl_o,
  input wire logic [3:0]  dev_ctl_oe,
  input wire logic [3:0]  hst_ctl_oe,
  input wire logic        gnt_n,
  input wire logic        idsel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence dev_start;
    dev_ctl_oe[3] && !ctl_n[3] && !$past(dev_ctl_oe[3]);
  endsequence
  sequence hst_start;
    hst_ctl_oe[3] && $fell(ctl_n[3]);
  endsequence
  sequence cfg_hit;
    hst_ctl_oe[3] && $fell(ctl_n[3]) && idsel && ad[1:0] == 2'h0 && cbe_n[3:1] == 3'h5;
  endsequence
  chk_mst_grant: assert property (dev_start |-> $past(!gnt_n))
    else $error("master start without grant");
  chk_mst_cmd: assert property (dev_start |-> cbe_n[3:1] == 3'h3)
    else $error("master command not memory read or write");
  chk_mst_irdy: assert property (dev_start |=> !ctl_n[2] && cbe_n == pbi_pkg::BE_ALL)
    else $error("master data phase lacks ready or full byte enables");
  chk_cfg_claim: assert property (cfg_hit |-> ##[1:2] !ctl_n[0])
    else $error("config access not claimed by second clock");
  chk_sel_cause: assert property (dev_ctl_oe[0] && !dev_ctl_o[0] && !$past(dev_ctl_oe[0])
    |-> $past(idsel, 2) || $past(cbe_n[3:1], 2) == 3'h1)
    else $error("device select without init select or io command");
  chk_frame_hold: assert property (dev_ctl_oe[3] && !ctl_n[3] && !ctl_n[0] && ctl_n[1]
    |=> !ctl_n[3])
    else $error("frame released while a beat is pending");
  chk_last_irdy: assert property (dev_ctl_oe[2] && ctl_n[3] && ctl_n[1:0] == 2'h0
    && !ctl_n[2] |=> ctl_n[2])
    else $error("ready kept after last data phase");
  chk_no_sel_abort: assert property (hst_start ##1 ctl_n[0] [*5] |=> ctl_n[2])
    else $error("unclaimed access not aborted");
endmodule

// ### tb/pci_bus_interface_signalling_tb.sv
// pci_bus_interface_signalling_tb: both ends joined, driven from user sides
// assumes core_clk is the bus clock at 200 MHz
`timescale 1ns/1ps
module pci_bus_interface_signalling_tb;
  localparam logic [31:0] ID   = 32'h1234_5678;  // arbitrary identity value
  localparam logic [31:0] BASE = 32'h2000_0100;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  evt_set = 8'h00;
  logic        mst_req = 1'b0;
  logic        mst_write = 1'b0;
  logic [3:0]  mst_len = 4'h0;
  logic [3:0]  mst_widx;
  logic [31:0] mst_rdata, mst_wdata, h_rdata, h_rd;
  logic        mst_rvalid, mst_done, mst_abort, h_done, h_abort, h_irq, h_ab;
  logic        h_req = 1'b0;
  logic        hi_on = 1'b0;
  logic [3:0]  h_cmd = 4'h0;
  logic [3:0]  h_be_n = 4'h0;
  logic [31:0] h_addr = 32'h0;
  logic [31:0] h_wdata = 32'h0;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          n_hi = 0;
  pbi_bus_if i_pbi_bus_if ();
  pbi_dev_end #(.NUM_EVT(8), .ID_WORD(ID)) i_pbi_dev_end (.core_clk(core_clk),
    .sys_rst(sys_rst), .bus(i_pbi_bus_if.dev), .evt_set(evt_set), .mst_req(mst_req),
    .mst_write(mst_write), .mst_addr(32'h0), .mst_len(mst_len), .mst_wdata(mst_wdata),
    .mst_widx(mst_widx), .mst_rdata(mst_rdata), .mst_rvalid(mst_rvalid),
    .mst_done(mst_done), .mst_abort(mst_abort));
  pbi_hst_end i_pbi_hst_end (.core_clk(core_clk), .sys_rst(sys_rst),
    .bus(i_pbi_bus_if.hst), .h_req(h_req), .h_cmd(h_cmd), .h_addr(h_addr),
    .h_be_n(h_be_n), .h_wdata(h_wdata), .h_rdata(h_rdata), .h_done(h_done),
    .h_abort(h_abort), .h_irq(h_irq));
  pbi_bus_properties i_pbi_bus_properties (.core_clk(core_clk), .sys_rst(sys_rst),
    .ad(i_pbi_bus_if.ad), .cbe_n(i_pbi_bus_if.cbe_n), .ctl_n(i_pbi_bus_if.ctl_n),
    .dev_ctl_o(i_pbi_bus_if.dev_ctl_o), .dev_ctl_oe(i_pbi_bus_if.dev_ctl_oe),
    .hst_ctl_oe(i_pbi_bus_if.hst_ctl_oe), .gnt_n(i_pbi_bus_if.gnt_n),
    .idsel(i_pbi_bus_if.idsel));
  always #2.5 core_clk = ~core_clk;
  // beat data follows its index, so order slips show up
  assign mst_wdata = 32'hc0de_0000 | {28'h0, mst_widx};
  always @(posedge core_clk) if (hi_on && i_pbi_bus_if.int_n === 1'b1) n_hi <= n_hi + 1;
  // settle after the edge so registered outputs are read stable
  task automatic tick; @(posedge core_clk); #1; endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic htx(logic [3:0] cmd, logic [31:0] addr, logic [3:0] be, logic [31:0] wd);
    h_cmd <= cmd;
    h_addr <= addr;
    h_be_n <= be;
    h_wdata <= wd;
    h_req <= 1'b1;
    for (int i = 0; i < 40 && h_done !== 1'b1; i++) tick;
    h_req <= 1'b0;
    h_ab = h_abort;
    h_rd = h_rdata;
    check("host done", 32'h1, {31'h0, h_done});
    repeat (2) tick;
  endtask
  task automatic mtx(logic wr, logic [3:0] len);
    int k;
    k = 0;
    mst_write <= wr;
    mst_len <= len;
    mst_req <= 1'b1;
    for (int i = 0; i < 60 && mst_done !== 1'b1; i++) begin
      tick;
      if (mst_rvalid === 1'b1) begin
        check("read beat", 32'hc0de_0000 | k, mst_rdata);
        k++;
      end
    end
    mst_req <= 1'b0;
    check("master abort", 32'h0, {31'h0, mst_abort});
    check("read beats", wr ? 0 : len, k);
    repeat (3) tick;
  endtask
  task automatic s_config;
    htx(pbi_pkg::CMD_CFG_WR, 32'h4, 4'h0, 32'h5);
    htx(pbi_pkg::CMD_CFG_RD, 32'h0, 4'h0, 32'h0);
    check("identity", ID, h_rd);
    htx(pbi_pkg::CMD_CFG_WR, 32'h10, 4'h0, 32'h0000_0100);
    htx(pbi_pkg::CMD_CFG_WR, 32'h10, 4'h7, 32'h20ff_ffff);
    htx(pbi_pkg::CMD_CFG_RD, 32'h10, 4'h0, 32'h0);
    check("base byte write", BASE, h_rd);
    htx(pbi_pkg::CMD_IO_RD, 32'h3000_0000, 4'h0, 32'h0);
    check("miss abort", 32'h1, {31'h0, h_ab});
  endtask
  task automatic pulse(logic [7:0] ev);
    evt_set <= ev;
    tick;
    evt_set <= 8'h00;
    repeat (4) tick;
  endtask
  task automatic s_irq;
    pulse(8'h02);
    check("masked line", 32'h0, {31'h0, h_irq});
    htx(pbi_pkg::CMD_IO_WR, BASE + 4, 4'h0, 32'h0);
    pulse(8'h01);
    check("raised line", 32'h1, {31'h0, h_irq});
    htx(pbi_pkg::CMD_IO_RD, BASE, 4'h0, 32'h0);
    check("status", 32'h3, h_rd);
    n_hi = 0;
    hi_on = 1'b1;
    htx(pbi_pkg::CMD_IO_WR, BASE, 4'h0, 32'h1);
    hi_on = 1'b0;
    check("gap cycles", 32'h1, n_hi);
    check("line again", 32'h1, {31'h0, h_irq});
    htx(pbi_pkg::CMD_IO_WR, BASE, 4'h0, 32'h2);
    repeat (3) tick;
    check("line cleared", 32'h0, {31'h0, h_irq});
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    tick;
    s_config;
    s_irq;
    mtx(1'b1, 4'h2);
    mtx(1'b0, 4'h2);
    close_out;
  end
  initial begin
    #20000;
    n_mismatch++;
    close_out;
  end
endmodule
